// file: src/rf_synth_divider_control.v
// RF synthesizer control words, serial loader, dividers and powerdown
// Operation
// - Reference divide is bits 17..3 of the first word, straight binary.
// - Bit 18 picks tuning sense; 0 swaps pump-up and pump-down.
// - Bit 19 picks pump current: 0 low 1 mA, 1 high 4 mA.
// - Bit 20 puts the pump output in high impedance at once.
// - High-impedance and powerdown bits together pick sync or async powerdown.
// - Bit 21 holds reference, swallow and binary counters in reset.
// - On release, feedback counters restart aligned with the reference counter.
// - Second word carries swallow, binary, prescaler select and powerdown fields.
// - Narrow variant: swallow count is bits 6..3, values 0 to 15.
// - Wide variant: swallow count is bits 7..3, values 0 to 31.
// - Words shift in MSB first: 21 data bits then 3 address bits.
// - Load strobe rise copies shift register to word chosen by address.
// - Sync powerdown waits for the next pump pulse; both bits: immediate.
`timescale 1ns/1ps
`default_nettype none
`include "rf_synth_consts.vh"

module rf_synth_divider_control #(
	parameter SWALLOW_BITS = 4
) (
	input wire clk,
	input wire resetn,
	input wire ser_clk,
	input wire ser_data,
	input wire load_strobe,
	input wire chip_enable,
	input wire ref_in,
	input wire presc_in,
	output wire pump_up,
	output wire pump_down,
	output wire pump_highz,
	output wire rf_pump_gain,
	output wire rf_prescaler_select,
	output wire modulus_high,
	output wire rf_powered_down
);

	localparam BINARY_BITS = `BINARY_MSB - `SWALLOW_LSB - SWALLOW_BITS + 1;

	reg [5:0] sync1_q;
	reg [5:0] sync2_q;
	reg [5:0] sync3_q;
	reg [`WORD_BITS-1:0] shift_q;
	reg [`WORD_BITS-1:0] ref_word_q;
	reg [`WORD_BITS-1:0] fb_word_q;
	reg up_q;
	reg down_q;
	reg [1:0] pd_state_q;
	reg [1:0] pd_state_d;
	wire ser_clk_rise;
	wire load_rise;
	wire ref_tick;
	wire presc_tick;
	wire ce_s;
	wire ref_event;
	wire fb_event;
	wire pulse_active;
	wire rf_detector_polarity;
	wire rf_pump_highz;
	wire rf_counter_reset;
	wire rf_powerdown;
	wire async_pd;
	wire sync_pd;
	wire hold;

	// Pins cross two flops; the third stage only feeds edge finding
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
			sync3_q <= 6'h00;
		end else begin
			sync1_q <= {presc_in, ref_in, chip_enable, load_strobe,
				ser_data, ser_clk};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Rising edges of the sampled pins, plus the synced chip enable level
	assign ser_clk_rise = sync2_q[0] & ~sync3_q[0];
	assign load_rise = sync2_q[2] & ~sync3_q[2];
	assign ce_s = sync2_q[3];
	assign ref_tick = sync2_q[4] & ~sync3_q[4];
	assign presc_tick = sync2_q[5] & ~sync3_q[5];

	// Serial shift register, data sampled on the same delay as clock
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_q <= {`WORD_BITS{1'b0}};
		end else if (ser_clk_rise) begin
			shift_q <= {shift_q[`WORD_BITS-2:0], sync2_q[1]};
		end
	end

	// Latch on load rise; unsupported addresses are dropped here
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_word_q <= `REF_WORD_RESET;
			fb_word_q <= `FB_WORD_RESET;
		end else if (load_rise) begin
			case (shift_q[`ADDR_MSB:`ADDR_LSB])
				`ADDR_REF_WORD: begin
					ref_word_q <= shift_q;
				end
				`ADDR_FB_WORD: begin
					fb_word_q <= shift_q;
				end
				default: begin
				end
			endcase
		end
	end

	// Field decode of the two control words
	assign rf_detector_polarity = ref_word_q[`POLARITY_BIT];
	assign rf_pump_gain = ref_word_q[`GAIN_BIT];
	assign rf_pump_highz = ref_word_q[`HIGHZ_BIT];
	assign rf_counter_reset = ref_word_q[`CNT_RESET_BIT];
	assign rf_prescaler_select = fb_word_q[`PRESC_SEL_BIT];
	assign rf_powerdown = fb_word_q[`POWERDOWN_BIT];

	// Powerdown mode from enable pin and the two control bits
	assign async_pd = ~ce_s | (rf_powerdown & rf_pump_highz);
	assign sync_pd = ce_s & rf_powerdown & ~rf_pump_highz;
	assign pulse_active = up_q | down_q;

	// Sync powerdown: wait for a pulse to start, then to finish
	always @* begin
		pd_state_d = pd_state_q;
		case (pd_state_q)
			`PD_ACTIVE: begin
				if (async_pd)
					pd_state_d = `PD_DOWN;
				else if (sync_pd)
					pd_state_d = pulse_active ? `PD_PULSE : `PD_WAIT;
			end
			`PD_WAIT: begin
				if (async_pd)
					pd_state_d = `PD_DOWN;
				else if (!sync_pd)
					pd_state_d = `PD_ACTIVE;
				else if (pulse_active)
					pd_state_d = `PD_PULSE;
			end
			`PD_PULSE: begin
				if (async_pd)
					pd_state_d = `PD_DOWN;
				else if (!sync_pd)
					pd_state_d = `PD_ACTIVE;
				else if (!pulse_active)
					pd_state_d = `PD_DOWN;
			end
			`PD_DOWN: begin
				if (!async_pd && !sync_pd)
					pd_state_d = `PD_ACTIVE;
			end
			default: begin
				pd_state_d = `PD_DOWN;
			end
		endcase
	end

	// Reset parks in powerdown so nothing pumps before programming
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pd_state_q <= `PD_DOWN;
		end else begin
			pd_state_q <= pd_state_d;
		end
	end

	assign rf_powered_down = (pd_state_q == `PD_DOWN);
	// Powerdown also holds dividers at their load point
	assign hold = rf_counter_reset | rf_powered_down;

	rf_counters #(
		.SW(SWALLOW_BITS),
		.BW(BINARY_BITS)
	) u_counters (
		.clk(clk),
		.resetn(resetn),
		.hold(hold),
		.ref_tick(ref_tick),
		.presc_tick(presc_tick),
		.ref_div(ref_word_q[`REF_DIV_MSB:`REF_DIV_LSB]),
		// Width 4 or 5 by variant
		.swallow(fb_word_q[`SWALLOW_LSB +: SWALLOW_BITS]),
		.binary(fb_word_q[`BINARY_MSB:`SWALLOW_LSB+SWALLOW_BITS]),
		.ref_event(ref_event),
		.fb_event(fb_event),
		.modulus_high(modulus_high)
	);

	// Phase detector: events set, coincidence clears both
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			up_q <= 1'b0;
			down_q <= 1'b0;
		end else if (hold || (up_q && down_q)) begin
			up_q <= 1'b0;
			down_q <= 1'b0;
		end else begin
			up_q <= up_q | ref_event;
			down_q <= down_q | fb_event;
		end
	end

	// Negative tuning sense swaps the pump directions
	assign pump_up = rf_detector_polarity ? up_q : down_q;
	assign pump_down = rf_detector_polarity ? down_q : up_q;
	// Not aligned to detector events; acts as soon as the word loads
	assign pump_highz = rf_pump_highz | rf_powered_down;

endmodule // rf_synth_divider_control

`default_nettype wire

// file: src/rf_synth_consts.vh
// Constants for the RF synthesizer divider control block
`ifndef RF_SYNTH_CONSTS_VH
`define RF_SYNTH_CONSTS_VH

// Serial word layout
`define WORD_BITS 24
`define ADDR_MSB 2
`define ADDR_LSB 0
`define ADDR_REF_WORD 3'h0
`define ADDR_FB_WORD 3'h1

// Reference control word fields
`define REF_DIV_MSB 17
`define REF_DIV_LSB 3
`define POLARITY_BIT 18
`define GAIN_BIT 19
`define HIGHZ_BIT 20
`define CNT_RESET_BIT 21

// Feedback control word fields
`define SWALLOW_LSB 3
`define BINARY_MSB 21
`define PRESC_SEL_BIT 22
`define POWERDOWN_BIT 23

// Reset values: synthesizer parked in powerdown until programmed
`define REF_WORD_RESET 24'h000000
`define FB_WORD_RESET 24'h800000

// Powerdown sequencer states
`define PD_ACTIVE 2'h0
`define PD_WAIT 2'h1
`define PD_PULSE 2'h2
`define PD_DOWN 2'h3

`endif

// file: src/rf_counters.v
// Reference divider and dual-modulus swallow feedback divider
`timescale 1ns/1ps
`default_nettype none

module rf_counters #(
	parameter SW = 4,
	parameter BW = 15
) (
	input wire clk,
	input wire resetn,
	input wire hold,
	input wire ref_tick,
	input wire presc_tick,
	input wire [14:0] ref_div,
	input wire [SW-1:0] swallow,
	input wire [BW-1:0] binary,
	output reg ref_event,
	output reg fb_event,
	output reg modulus_high
);

	reg [14:0] ref_cnt_q;
	reg [BW-1:0] b_cnt_q;
	reg [SW-1:0] a_cnt_q;

	// Reference counter: one event every ref_div reference edges
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_cnt_q <= 15'h0000;
			ref_event <= 1'b0;
		end else begin
			ref_event <= 1'b0;
			if (hold) begin
				ref_cnt_q <= ref_div; // Held at load point
			end else if (ref_tick) begin
				// Values below 3 are illegal; they just divide oddly
				if (ref_cnt_q <= 15'h0001) begin
					ref_cnt_q <= ref_div;
					ref_event <= 1'b1;
				end else begin
					ref_cnt_q <= ref_cnt_q - 15'h0001;
				end
			end
		end
	end

	// Swallow divider: first A prescaler cycles at high modulus
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			b_cnt_q <= {BW{1'b0}};
			a_cnt_q <= {SW{1'b0}};
			modulus_high <= 1'b0;
			fb_event <= 1'b0;
		end else begin
			fb_event <= 1'b0;
			if (hold) begin
				// Both dividers leave the load point together
				b_cnt_q <= binary;
				a_cnt_q <= swallow;
				modulus_high <= (swallow != {SW{1'b0}});
			end else if (presc_tick) begin
				if (b_cnt_q <= {{(BW-1){1'b0}}, 1'b1}) begin
					// Total count is P*B + A
					b_cnt_q <= binary;
					a_cnt_q <= swallow;
					modulus_high <= (swallow != {SW{1'b0}});
					fb_event <= 1'b1;
				end else begin
					b_cnt_q <= b_cnt_q - {{(BW-1){1'b0}}, 1'b1};
					if (a_cnt_q != {SW{1'b0}}) begin
						a_cnt_q <= a_cnt_q - {{(SW-1){1'b0}}, 1'b1};
						modulus_high <= (a_cnt_q != {{(SW-1){1'b0}}, 1'b1});
					end
				end
			end
		end
	end

endmodule // rf_counters

`default_nettype wire

// file: tb/rf_host_model.sv
// Host model driving the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module rf_host_model (
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic load_strobe
);
	// Pins idle low until the first word
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		load_strobe = 1'b0;
	end
	// One word, MSB first, 400 ns bit period
	task automatic send(input logic [23:0] w);
		// Never hand the device a reference divide below 3
		if (w[2:0] == 3'h0 && w[17:3] < 15'h0003)
			w[17:3] = 15'h0003;
		@(posedge clk) #1;
		for (int i = 23; i >= 0; i--) begin
			ser_data = w[i];
			#150 ser_clk = 1'b1;
			#200 ser_clk = 1'b0;
			#50;
		end
		// No pull on data, so never leave a stale bit
		ser_data = ~ser_data;
		load_strobe = 1'b1;
		#200 load_strobe = 1'b0;
		#300;
	endtask
endmodule // rf_host_model
`default_nettype wire

// file: tb/rf_synth_divider_control_monitor.sv
// Port checker for the divider control block
`timescale 1ns/1ps
`default_nettype none
module rf_synth_divider_control_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic load_strobe,
	input wire logic chip_enable,
	input wire logic pump_up,
	input wire logic pump_down,
	input wire logic pump_highz,
	input wire logic rf_pump_gain,
	input wire logic rf_prescaler_select,
	input wire logic modulus_high,
	input wire logic rf_powered_down
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Word fields may only move right after a load
	chk_gain_on_load: assert property ($changed(rf_pump_gain) |->
		$past(load_strobe, 2) || $past(load_strobe, 3))
		else $error("gain moved without a load");
	chk_presc_on_load: assert property (
		$changed(rf_prescaler_select) |->
		$past(load_strobe, 2) || $past(load_strobe, 3))
		else $error("prescaler select moved without a load");
	// One cycle into powerdown the pumps must be idle and released
	chk_highz_down: assert property (
		rf_powered_down && $past(rf_powered_down) |->
		pump_highz && !pump_up && !pump_down)
		else $error("pump driven while down");
	chk_ce_low_down: assert property (
		!chip_enable [*6] |-> rf_powered_down)
		else $error("chip enable low but not down");
	chk_pumps_clear: assert property (
		pump_up && pump_down |=> !pump_up && !pump_down)
		else $error("pumps not cleared");
	chk_up_live: assert property (
		$rose(pump_up) |-> !$past(rf_powered_down, 2))
		else $error("pump up while down");
	chk_down_live: assert property (
		$rose(pump_down) |-> !$past(rf_powered_down, 2))
		else $error("pump down while down");
	// A load while down may move the load point, so skip those cycles
	chk_mod_frozen: assert property (
		rf_powered_down && $past(rf_powered_down) &&
		$past(rf_powered_down, 2) && !$past(load_strobe, 3) &&
		!$past(load_strobe, 4) |-> $stable(modulus_high))
		else $error("divider ran while down");
endmodule // rf_synth_divider_control_monitor
bind rf_synth_divider_control rf_synth_divider_control_monitor
	rf_synth_divider_control_monitor_inst (.clk(clk), .resetn(resetn),
	.load_strobe(load_strobe), .chip_enable(chip_enable),
	.pump_up(pump_up), .pump_down(pump_down), .pump_highz(pump_highz),
	.rf_pump_gain(rf_pump_gain),
	.rf_prescaler_select(rf_prescaler_select),
	.modulus_high(modulus_high), .rf_powered_down(rf_powered_down));
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the divider control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, resetn, chip_enable;
	logic [3:0] pin_div = 4'h0;
	wire ref_in, presc_in;
	wire ser_clk, ser_data, load_strobe;
	wire pump_up, pump_down, pump_highz, gain, psel, mod_hi, down;
	int num_errors = 0, total_checks = 0;
	// Four-state so an unknown pump level cannot count as zero
	integer n_up, n_dn, n_mod;
	// Clocks; pins toggle off the clk edges
	always #25 clk = ~clk;
	// Oscillator and prescaler pins step just after clk rises
	always @(posedge clk) begin
		#1;
		pin_div <= pin_div + 4'h1;
	end
	assign presc_in = pin_div[2];
	assign ref_in = pin_div[3];
	rf_host_model rf_host_model_inst (.clk(clk), .ser_clk(ser_clk),
		.ser_data(ser_data), .load_strobe(load_strobe));
	rf_synth_divider_control rf_synth_divider_control_inst (.clk(clk),
		.resetn(resetn), .ser_clk(ser_clk), .ser_data(ser_data),
		.load_strobe(load_strobe), .chip_enable(chip_enable),
		.ref_in(ref_in), .presc_in(presc_in), .pump_up(pump_up),
		.pump_down(pump_down), .pump_highz(pump_highz),
		.rf_pump_gain(gain), .rf_prescaler_select(psel),
		.modulus_high(mod_hi), .rf_powered_down(down));
	task chk(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %b expected %b", $time, got, exp);
		end
	endtask
	// Reference word with divide by 3
	function logic [23:0] rw(input logic rst, hz, g, pol);
		return {2'h0, rst, hz, g, pol, 15'h0003, 3'h0};
	endfunction
	// Feedback word: A=1, B=3, swallow must not exceed binary
	function logic [23:0] fw(input logic pd);
		return {pd, 1'b1, 15'h0003, 4'h1, 3'h1};
	endfunction
	// Count cycles each pump side and the swallow phase are high
	task run(input int n);
		n_up = 0;
		n_dn = 0;
		n_mod = 0;
		repeat (n) begin
			@(posedge clk) #1;
			n_up += pump_up;
			n_dn += pump_down;
			n_mod += mod_hi;
		end
	endtask
	task t_fields;
		rf_host_model_inst.send(rw(0, 1, 1, 1));
		chk(gain, 1);
		chk(pump_highz, 1);
		rf_host_model_inst.send(fw(0));
		chk(down, 0);
		chk(pump_highz, 1);
		chk(psel, 1);
		rf_host_model_inst.send({1'b1, 20'h0, 3'h2});
		chk(down, 0);
		rf_host_model_inst.send(rw(0, 0, 0, 1));
		chk(gain, 0);
		chk(pump_highz, 0);
	endtask
	// Feedback runs faster than reference here
	task t_divide;
		run(400);
		chk(n_dn > n_up, 1);
		chk(n_mod > 0 && n_mod < 200, 1);
		rf_host_model_inst.send(rw(0, 0, 0, 0));
		run(400);
		chk(n_up > n_dn, 1);
		rf_host_model_inst.send(rw(1, 0, 0, 1));
		run(100);
		chk(n_up == 0 && n_dn == 0, 1);
		chk(n_mod % 100 == 0, 1);
		rf_host_model_inst.send(rw(0, 0, 0, 1));
		run(100);
		chk(n_up + n_dn > 0, 1);
	endtask
	task t_down;
		rf_host_model_inst.send(fw(1));
		repeat (150) @(posedge clk);
		#1 chk(down, 1);
		rf_host_model_inst.send(fw(0));
		chk(down, 0);
		@(posedge clk) #1 chip_enable = 0;
		repeat (8) @(posedge clk);
		#1 chk(down, 1);
		chip_enable = 1;
		rf_host_model_inst.send(rw(0, 1, 0, 1));
		rf_host_model_inst.send(fw(1));
		chk(down, 1);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Reset, then the scenarios
	initial begin
		clk = 0;
		resetn = 0;
		chip_enable = 1;
		repeat (3) @(posedge clk);
		#1 resetn = 1;
		chk(down, 1);
		chk(mod_hi, 0);
		chk(psel, 0);
		chk(gain, 0);
		t_fields;
		t_divide;
		t_down;
		print_verdict;
	end
	// Watchdog well past the expected run length
	initial begin
		#2000000;
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		print_verdict;
	end
endmodule // tb
`default_nettype wire
